//--- core/mspd_debounce.sv
// Three-flop synchroniser and debounce filter for one push-button pin.
// Assumes a one-cycle millisecond tick from the parent.
`timescale 1ns/100ps
module mspd_debounce (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic ms_tick_in,
    input wire logic pin_in,
    output logic level_out
);
    import mspd_pkg::*;
    logic [2:0] sync_q;
    logic [mspd_pkg::MS_W-1:0] stable_q;
    wire agree = sync_q[1] == sync_q[2];
    wire differ = agree && (sync_q[2] != level_out);
    wire settled = stable_q >= DEBOUNCE_LEN;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], pin_in};
        end
    end

    // Level must stay changed for the whole window before it is taken
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            stable_q <= MS_ZERO;
            level_out <= 1'b0;
        end else if (!differ) begin
            stable_q <= MS_ZERO;
        end else if (settled) begin
            level_out <= sync_q[2];
            stable_q <= MS_ZERO;
        end else if (ms_tick_in) begin
            stable_q <= stable_q + MS_ONE;
        end
    end
endmodule

//--- core/mspd_pkg.sv
// Constants and types for the mode switch press decoder.
// Assumes a single 10 MHz system clock; all times stay millisecond counts here.
// What this block does
// - Hold between two and ten seconds reboots into serial configuration mode.
// - Ready LED blinks while the mode button stays pressed.
// - Ready LED stays off throughout serial configuration mode once booted.
// - Reset switch held two seconds leaves configuration mode.
// - A completed configuration save also leaves configuration mode.
// - Hold under two seconds then release gives hardware reset to normal.
// - Ready LED blinks after short-press reset completes and normal runs.
// - Hold over ten seconds restores factory defaults then reboots, with no hardware reset pulse.
// - Past ten seconds, ready LED flashes three times per second.
// - Ready LED blinks after factory reload and reboot.
// - LEDs return to ordinary patterns once normal operation resumes.
// - Socket bridge mode passes socket data unchanged to serial and back.
// - After console-length release, ready LED blinks about five seconds.
// - First serial indicator lit continuously during configuration mode.
package mspd_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int unsigned CONSOLE_MIN_MS = 2000;
    localparam int unsigned DEFAULTS_MIN_MS = 10000;
    localparam int unsigned EXIT_HOLD_MS = 2000;
    localparam int unsigned REBOOT_MS = 5000;
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned SLOW_HALF_MS = 250;
    // Three flashes per second: one period is 333 ms, half rounded down
    localparam int unsigned FAST_HALF_MS = 166;
    localparam int unsigned MS_W = 16;
    localparam logic [MS_W-1:0] CONSOLE_MIN = MS_W'(CONSOLE_MIN_MS);
    localparam logic [MS_W-1:0] DEFAULTS_MIN = MS_W'(DEFAULTS_MIN_MS);
    localparam logic [MS_W-1:0] EXIT_HOLD = MS_W'(EXIT_HOLD_MS);
    localparam logic [MS_W-1:0] REBOOT_LEN = MS_W'(REBOOT_MS);
    localparam logic [MS_W-1:0] DEBOUNCE_LEN = MS_W'(DEBOUNCE_MS);
    localparam logic [MS_W-1:0] SLOW_HALF = MS_W'(SLOW_HALF_MS);
    localparam logic [MS_W-1:0] FAST_HALF = MS_W'(FAST_HALF_MS);
    localparam logic [MS_W-1:0] MS_ONE = 16'h0001;
    localparam logic [MS_W-1:0] MS_ZERO = 16'h0000;

    typedef enum logic [5:0] {
        MSPD_NORMAL   = 6'h01,
        MSPD_HELD     = 6'h02,
        MSPD_RESET    = 6'h04,
        MSPD_DEFAULTS = 6'h08,
        MSPD_REBOOT   = 6'h10,
        MSPD_CONSOLE  = 6'h20
    } mspd_state_t;
endpackage

//--- core/mspd_top.sv
// Mode switch press decoder: times button holds and sequences LEDs.
// Assumes active-high pressed buttons and a firmware boot-done strobe.
`timescale 1ns/100ps
module mspd_top #(
    // Cycles per millisecond tick; a bench may shorten it
    parameter int unsigned TICK_CYCLES = mspd_pkg::CYC_PER_MS
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic mode_btn_in,
    input wire logic reset_sw_in,
    input wire logic boot_done_in,
    input wire logic cfg_saved_in,
    input wire logic [7:0] socket_rx_data_in,
    input wire logic socket_rx_valid_in,
    input wire logic [7:0] serial_rx_data_in,
    input wire logic serial_rx_valid_in,
    output logic hw_reset_out,
    output logic load_defaults_out,
    output logic console_mode_out,
    output logic socket_bridge_mode_out,
    output logic ready_led_out,
    output logic first_serial_indicator_out,
    output logic [7:0] serial_tx_data_out,
    output logic serial_tx_valid_out,
    output logic [7:0] socket_tx_data_out,
    output logic socket_tx_valid_out
);
    import mspd_pkg::*;

    logic [13:0] pre_q;
    logic ms_tick_q;
    logic btn_lvl;
    logic sw_lvl;
    logic btn_prev_q;
    logic [MS_W-1:0] hold_q;
    logic [MS_W-1:0] sw_q;
    logic [MS_W-1:0] reb_q;
    logic [MS_W-1:0] blink_q;
    logic blink_q_led;
    logic to_console_q;
    logic booting_q;
    mspd_state_t state_q;
    mspd_state_t state_d;

    wire pre_wrap = pre_q == 14'(TICK_CYCLES - 1);
    wire released = btn_prev_q && !btn_lvl;
    wire pressed = !btn_prev_q && btn_lvl;
    wire band_fast = hold_q > DEFAULTS_MIN;
    wire band_console = hold_q >= CONSOLE_MIN && !band_fast;
    // Fast rate only during the hold; the stale hold time must not linger
    wire fast_blink = band_fast && state_q == MSPD_HELD;
    wire [MS_W-1:0] half = fast_blink ? FAST_HALF : SLOW_HALF;
    wire sw_exit = sw_q >= EXIT_HOLD;
    wire reb_over = reb_q >= REBOOT_LEN;
    wire in_console = state_q == MSPD_CONSOLE;

    mspd_debounce u_btn (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .ms_tick_in(ms_tick_q),
        .pin_in(mode_btn_in),
        .level_out(btn_lvl)
    );
    mspd_debounce u_sw (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .ms_tick_in(ms_tick_q),
        .pin_in(reset_sw_in),
        .level_out(sw_lvl)
    );

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pre_q <= 14'h0000;
            ms_tick_q <= 1'b0;
        end else begin
            pre_q <= pre_wrap ? 14'h0000 : pre_q + 14'h0001;
            ms_tick_q <= pre_wrap;
        end
    end

    // Action is chosen only at release, so a long hold never fires early
    always_comb begin
        state_d = state_q;
        case (state_q)
            MSPD_NORMAL: begin
                if (pressed) begin
                    state_d = MSPD_HELD;
                end
            end
            MSPD_HELD: begin
                if (released && band_fast) begin
                    state_d = MSPD_DEFAULTS;
                end else if (released && band_console) begin
                    state_d = MSPD_REBOOT;
                end else if (released) begin
                    state_d = MSPD_RESET;
                end
            end
            MSPD_RESET: state_d = MSPD_REBOOT;
            MSPD_DEFAULTS: state_d = MSPD_REBOOT;
            MSPD_REBOOT: begin
                if (boot_done_in && reb_over) begin
                    state_d = to_console_q ? MSPD_CONSOLE : MSPD_NORMAL;
                end
            end
            MSPD_CONSOLE: begin
                if (sw_exit || cfg_saved_in) begin
                    state_d = MSPD_RESET;
                end
            end
            default: state_d = MSPD_NORMAL;
        endcase
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= MSPD_NORMAL;
            btn_prev_q <= 1'b0;
            to_console_q <= 1'b0;
        end else begin
            state_q <= state_d;
            btn_prev_q <= btn_lvl;
            if (state_q == MSPD_HELD && released) begin
                to_console_q <= band_console;
            end else if (in_console && state_d != MSPD_CONSOLE) begin
                to_console_q <= 1'b0;
            end
        end
    end

    // Hold timer saturates so very long presses stay in the top band
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold_q <= MS_ZERO;
            sw_q <= MS_ZERO;
            reb_q <= MS_ZERO;
        end else begin
            if (pressed) begin
                hold_q <= MS_ZERO;
            end else if (btn_lvl && ms_tick_q && !(&hold_q)) begin
                hold_q <= hold_q + MS_ONE;
            end
            if (!sw_lvl || !in_console) begin
                sw_q <= MS_ZERO;
            end else if (ms_tick_q && !sw_exit) begin
                sw_q <= sw_q + MS_ONE;
            end
            if (state_q != MSPD_REBOOT) begin
                reb_q <= MS_ZERO;
            end else if (ms_tick_q && !reb_over) begin
                reb_q <= reb_q + MS_ONE;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            blink_q <= MS_ZERO;
            blink_q_led <= 1'b0;
        end else if (ms_tick_q) begin
            if (blink_q >= half - MS_ONE) begin
                blink_q <= MS_ZERO;
                blink_q_led <= !blink_q_led;
            end else begin
                blink_q <= blink_q + MS_ONE;
            end
        end
    end

    // Normal running shows a slow blink as the ordinary ready pattern
    wire led_d = in_console ? 1'b0 : blink_q_led;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hw_reset_out <= 1'b0;
            load_defaults_out <= 1'b0;
            console_mode_out <= 1'b0;
            socket_bridge_mode_out <= 1'b0;
            ready_led_out <= 1'b0;
            first_serial_indicator_out <= 1'b0;
            booting_q <= 1'b0;
        end else begin
            hw_reset_out <= state_q == MSPD_RESET;
            load_defaults_out <= state_q == MSPD_DEFAULTS;
            console_mode_out <= in_console;
            socket_bridge_mode_out <= state_q == MSPD_NORMAL;
            ready_led_out <= led_d;
            first_serial_indicator_out <= in_console;
            booting_q <= state_q == MSPD_REBOOT;
        end
    end

    // Bridge passes bytes unchanged, only while running normally
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            serial_tx_data_out <= 8'h00;
            serial_tx_valid_out <= 1'b0;
            socket_tx_data_out <= 8'h00;
            socket_tx_valid_out <= 1'b0;
        end else begin
            serial_tx_data_out <= socket_rx_data_in;
            serial_tx_valid_out <= socket_rx_valid_in && !booting_q
                && state_q == MSPD_NORMAL;
            socket_tx_data_out <= serial_rx_data_in;
            socket_tx_valid_out <= serial_rx_valid_in && !booting_q
                && state_q == MSPD_NORMAL;
        end
    end
endmodule

//--- test/mspd_button_model.sv
// Push-button and LED observer standing beside the decoder.
// Assumes high means pressed; the mode button bounces before settling, the reset switch does not.
`timescale 1ns/100ps
module mspd_button_model #(
    parameter int unsigned CYC_MS = 10000
) (
    input wire logic core_clk_in,
    input wire logic ready_led_in,
    output logic mode_btn_out,
    output logic reset_sw_out
);
    int led_edges = 0;

    initial begin
        mode_btn_out = 1'b0;
        reset_sw_out = 1'b0;
    end

    always @(ready_led_in) led_edges++;

    // Short bounce, then a clean hold of ms milliseconds
    task automatic press_mode(input int ms);
        repeat (2) begin
            @(posedge core_clk_in) #1 mode_btn_out = 1'b1;
            @(posedge core_clk_in) #1 mode_btn_out = 1'b0;
        end
        @(posedge core_clk_in) #1 mode_btn_out = 1'b1;
        repeat (ms * CYC_MS) @(posedge core_clk_in);
        #1 mode_btn_out = 1'b0;
    endtask

    task automatic hold_reset(input int ms);
        @(posedge core_clk_in) #1 reset_sw_out = 1'b1;
        repeat (ms * CYC_MS) @(posedge core_clk_in);
        #1 reset_sw_out = 1'b0;
    endtask
endmodule

//--- test/mspd_top_asserts.sv
// Port-level checks for the mode switch press decoder.
// Bound to every mspd_top; sees only its ports.
`timescale 1ns/100ps
module mspd_top_asserts (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic cfg_saved_in,
    input wire logic [7:0] socket_rx_data_in,
    input wire logic socket_rx_valid_in,
    input wire logic [7:0] serial_rx_data_in,
    input wire logic serial_rx_valid_in,
    input wire logic hw_reset_out,
    input wire logic load_defaults_out,
    input wire logic console_mode_out,
    input wire logic socket_bridge_mode_out,
    input wire logic ready_led_out,
    input wire logic first_serial_indicator_out,
    input wire logic [7:0] serial_tx_data_out,
    input wire logic serial_tx_valid_out,
    input wire logic [7:0] socket_tx_data_out,
    input wire logic socket_tx_valid_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    a_reset_pulse_single: assert property (hw_reset_out |=> !hw_reset_out)
        else $error("hw reset pulse longer than one cycle");
    a_defaults_pulse_single: assert property (
        load_defaults_out |=> !load_defaults_out)
        else $error("defaults pulse longer than one cycle");
    a_console_led_off: assert property (console_mode_out |-> !ready_led_out)
        else $error("ready led lit in console mode");
    a_console_port_lit: assert property (
        console_mode_out |-> first_serial_indicator_out)
        else $error("first serial indicator dark in console mode");
    a_modes_exclusive: assert property (
        !(console_mode_out && socket_bridge_mode_out))
        else $error("console and bridge modes together");
    a_save_exits_console: assert property (
        console_mode_out && cfg_saved_in |-> ##2 hw_reset_out && !console_mode_out)
        else $error("save did not leave console mode");
    a_bridge_to_serial: assert property (
        socket_rx_valid_in && socket_bridge_mode_out |=> serial_tx_valid_out
        && serial_tx_data_out == $past(socket_rx_data_in))
        else $error("socket byte not copied to serial");
    a_bridge_to_socket: assert property (
        serial_rx_valid_in && socket_bridge_mode_out |=> socket_tx_valid_out
        && socket_tx_data_out == $past(serial_rx_data_in))
        else $error("serial byte not copied to socket");
    a_no_idle_tx: assert property (
        !socket_rx_valid_in && !serial_rx_valid_in
        |=> !serial_tx_valid_out && !socket_tx_valid_out)
        else $error("tx valid without received byte");
endmodule

bind mspd_top mspd_top_asserts chk_u (.*);

//--- test/test_mode_switch_press_decoder.sv
// Self-checking bench: reset state, byte bridge, short press reset, console entry and exits, factory defaults.
// Assumes the 10 MHz clock and the 20 ms debounce of the design.
`timescale 1ns/100ps
module test_mode_switch_press_decoder;
    import mspd_pkg::*;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic boot_done_in = 1'b0;
    logic cfg_saved_in = 1'b0;
    logic [7:0] srx_d = 8'h00, prx_d = 8'h00;
    logic srx_v = 1'b0, prx_v = 1'b0;
    logic mode_btn, reset_sw, hw_rst, dflt, cons, brdg, led, p1;
    logic [7:0] ptx_d, stx_d;
    logic ptx_v, stx_v;
    int err_count = 0;
    int comparisons = 0;

    // One-cycle millisecond tick keeps every hold short in simulation
    mspd_top #(.TICK_CYCLES(1)) dut_u (
        .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .mode_btn_in(mode_btn), .reset_sw_in(reset_sw),
        .boot_done_in(boot_done_in), .cfg_saved_in(cfg_saved_in),
        .socket_rx_data_in(srx_d), .socket_rx_valid_in(srx_v),
        .serial_rx_data_in(prx_d), .serial_rx_valid_in(prx_v),
        .hw_reset_out(hw_rst), .load_defaults_out(dflt),
        .console_mode_out(cons), .socket_bridge_mode_out(brdg),
        .ready_led_out(led), .first_serial_indicator_out(p1),
        .serial_tx_data_out(stx_d), .serial_tx_valid_out(stx_v),
        .socket_tx_data_out(ptx_d), .socket_tx_valid_out(ptx_v));
    mspd_button_model #(.CYC_MS(1)) btn_u (
        .core_clk_in(core_clk_in), .ready_led_in(led),
        .mode_btn_out(mode_btn), .reset_sw_out(reset_sw));

    initial begin
        forever #50 core_clk_in = ~core_clk_in;
    end

    task automatic end_sim();
        if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h", $time, what, got);
        end
    endtask

    task automatic test_reset();
        @(posedge core_clk_in) #1
            check({hw_rst, dflt, cons, led, p1, stx_v, ptx_v}, 8'h00, "rst");
        repeat (2) @(posedge core_clk_in);
        #1 sys_rst_in = 1'b0;
        repeat (3) @(posedge core_clk_in);
        #1 check({7'h00, brdg}, 8'h01, "bridge mode");
        check({7'h00, cons}, 8'h00, "console mode");
    endtask

    task automatic test_bridge();
        logic [7:0] pats [3] = '{8'h00, 8'h5a, 8'hff};
        foreach (pats[i]) begin
            srx_d = pats[i];
            prx_d = ~pats[i];
            srx_v = 1'b1;
            prx_v = 1'b1;
            @(posedge core_clk_in) #1 srx_v = 1'b0;
            prx_v = 1'b0;
            check({stx_v, ptx_v, 6'h00}, 8'hc0, "tx valid");
            check(stx_d, pats[i], "serial data");
            check(ptx_d, ~pats[i], "socket data");
            @(posedge core_clk_in) #1 check({stx_v, ptx_v}, 8'h00, "idle tx");
        end
    endtask

    task automatic test_short_press();
        int e0, n;
        boot_done_in = 1'b1;
        e0 = btn_u.led_edges;
        btn_u.press_mode(600);
        check({7'h00, btn_u.led_edges > e0}, 8'h01, "led blink held");
        n = 0;
        while (hw_rst !== 1'b1 && n < 400) begin
            @(posedge core_clk_in) #1 n++;
        end
        check({7'h00, hw_rst}, 8'h01, "hw reset pulse");
        check({7'h00, dflt | cons}, 8'h00, "wrong action");
        @(posedge core_clk_in) #1 check({7'h00, hw_rst}, 8'h00, "pulse end");
        wait_normal();
        e0 = btn_u.led_edges;
        repeat (600) @(posedge core_clk_in);
        #1 check({7'h00, btn_u.led_edges > e0}, 8'h01, "led after");
    endtask

    // Waits for normal running again and checks it arrived
    task automatic wait_normal();
        int n;
        n = 0;
        while (brdg !== 1'b1 && n < 8000) begin
            @(posedge core_clk_in) #1 n++;
        end
        check({6'h00, brdg, cons}, 8'h02, "back to normal");
    endtask

    task automatic enter_console();
        int n;
        btn_u.press_mode(3000);
        n = 0;
        while (cons !== 1'b1 && n < 8000) begin
            @(posedge core_clk_in) #1 n++;
        end
        check({6'h00, cons, p1}, 8'h03, "console entry");
        repeat (600) @(posedge core_clk_in);
        #1 check({7'h00, led}, 8'h00, "led off in console");
    endtask

    task automatic test_console();
        enter_console();
        cfg_saved_in = 1'b1;
        @(posedge core_clk_in) #1 cfg_saved_in = 1'b0;
        @(posedge core_clk_in) #1
            check({6'h00, hw_rst, cons}, 8'h02, "save exit");
        wait_normal();
        enter_console();
        btn_u.hold_reset(2100);
        #1 check({7'h00, cons}, 8'h00, "switch exit");
        wait_normal();
    endtask

    task automatic test_defaults();
        int n;
        btn_u.press_mode(10500);
        n = 0;
        while (dflt !== 1'b1 && n < 400) begin
            @(posedge core_clk_in) #1 n++;
        end
        check({6'h00, dflt, hw_rst}, 8'h02, "defaults pulse");
        wait_normal();
    endtask

    initial begin
        // About 80000 cycles; the scenarios need roughly 50000
        #8000000;
        err_count++;
        end_sim();
    end

    initial begin
        test_reset();
        test_bridge();
        test_short_press();
        test_console();
        test_defaults();
        end_sim();
    end
endmodule
